//--- inc/sicp_consts.vh
// Purpose: shared constants of the serial / two-wire configuration port
// Assumes: included by bare name from every design file but sicp_pin_sync
// Notes:   codes and counts only, no logic
`ifndef SICP_CONSTS_VH
`define SICP_CONSTS_VH

// mode-select codes, captured on the rise of ready
`define SICP_MODE_SERIAL  3'h5
`define SICP_MODE_TWIRE   3'h4
`define SICP_MODE_W       3

// two-wire slave address and direction bit value for a write
`define SICP_SLAVE_ADDR   7'h50
`define SICP_DIR_WRITE    1'h0

// frame length in bits, ack is the pulse after
`define SICP_FRAME_BITS   4'h8

// reset values of handshake pins
`define SICP_READY_RST    1'h0
`define SICP_DONE_RST     1'h0

// ready high pulse length, in ns and in ref_clk cycles at 8 ns
`define SICP_READY_NS     64
`define SICP_CLK_NS       8
`define SICP_READY_CYC    ((`SICP_READY_NS + `SICP_CLK_NS - 1) / `SICP_CLK_NS)

// restart pin low time, least, to count as a pulse
`define SICP_RESTART_NS   40
`define SICP_RESTART_CYC  ((`SICP_RESTART_NS + `SICP_CLK_NS - 1) / `SICP_CLK_NS)

`endif

//--- hw/sicp_pin_sync.v
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: input is asynchronous to clk
// Notes:   output changes when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module sicp_pin_sync #(
	parameter RST_VAL = 1'b1
) (
	input  wire clk,
	input  wire rst_n,
	input  wire pinIn,
	output reg  level_q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	// first stage feeds only the second, reset value is a constant
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= RST_VAL;
			s2_q    <= RST_VAL;
			s3_q    <= RST_VAL;
			level_q <= RST_VAL;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level_q <= s3_q;  // filters a single-sample glitch
		end
	end
endmodule // sicp_pin_sync
`default_nettype wire

//--- hw/sicp_shift_byte.v
// Purpose: msb-first byte assembler with a bit counter
// Assumes: shiftEn is a one-cycle pulse per captured bit
// Notes:   byteDone pulses with the eighth bit; clear restarts the count
`timescale 1ns/10ps
`default_nettype none
`include "sicp_consts.vh"
module sicp_shift_byte (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       clear,
	input  wire       shiftEn,
	input  wire       bitIn,
	output reg  [7:0] byte_q,
	output reg  [3:0] count_q,
	output wire       byteDone
);
	assign byteDone = shiftEn && (count_q == (`SICP_FRAME_BITS - 4'h1));

	// shift left so the first bit lands in bit 7
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_q  <= 8'h00;
			count_q <= 4'h0;
		end else if (clear) begin
			count_q <= 4'h0;
		end else if (shiftEn) begin
			byte_q  <= {byte_q[6:0], bitIn};
			count_q <= byteDone ? 4'h0 : count_q + 4'h1;
		end
	end
endmodule // sicp_shift_byte
`default_nettype wire

//--- hw/sicp_config_port.v
// Purpose: write-only configuration port, serial and two-wire slave links
// Assumes: ref_clk 125 MHz; link clocks far slower, sampled as data
// Notes:   bytes leave on cfgByte/cfgValid; no readback path exists
// Notes on behaviour
// - serial mode only takes bitstream writes, nothing is read back.
// - restart low pulse or power cycle begins a fresh configuration.
// - ready pulses high when programming allowed, low otherwise.
// - done high after success, low while incomplete or failed.
// - mode-select pins captured on ready rising edge, choose the port.
// - code 101 picks serial, code 100 picks two-wire.
// - cascade output driven only in serial mode when chained.
// - ports usable only when restart pin not reused as general I/O.
// - two-wire mode first tries internal flash boot after power-on.
// - two-wire mode accepts writes only, no identifier or status reads.
// - data line driven by device only for acknowledge bits.
// - start and stop conditions detected while clock line high.
// - slave address 1010000, clock up to 1.33 MHz.
// - bit after address is 0 for write, 1 for read.
// - every accepted frame answered by acknowledge driven 0.
// - frames are eight bits, most significant first.
// - ninth pulse carries acknowledge; release means no-acknowledge.
// - acknowledge driven in low phase before ninth pulse, held through.
// - data stable while clock high, changes only while low.
// - idle lines both high, nobody pulls them low.
`timescale 1ns/10ps
`default_nettype none
`include "sicp_consts.vh"
module sicp_config_port #(
	parameter READY_CYC = `SICP_READY_CYC
) (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire       restartPin_n,
	input  wire       restartIsGpio,
	input  wire [2:0] modePins,
	input  wire       chainEn,
	input  wire       serClk,
	input  wire       serData,
	output reg        serCascade_q,
	input  wire       twScl,
	input  wire       twSdaIn,
	output wire       twSdaOut,
	output wire       twSdaOe,
	output reg        ready_q,
	output reg        done_q,
	output reg  [2:0] modeCap_q,
	input  wire       flashHasImage,
	input  wire       flashBootDone,
	input  wire       flashBootOk,
	output reg        flashBootReq_q,
	input  wire       cfgComplete,
	input  wire       cfgFail,
	output reg  [7:0] cfgByte_q,
	output reg        cfgValid_q
);
	// top-level states
	localparam ST_IDLE  = 3'h0;
	localparam ST_FLASH = 3'h1;
	localparam ST_READY = 3'h2;
	localparam ST_LOAD  = 3'h3;
	localparam ST_DONE  = 3'h4;
	localparam ST_FAIL  = 3'h5;
	// two-wire slave states
	localparam TW_IDLE = 3'h0;
	localparam TW_ADDR = 3'h1;
	localparam TW_AACK = 3'h2;
	localparam TW_DATA = 3'h3;
	localparam TW_DACK = 3'h4;
	localparam TW_SKIP = 3'h5;

	wire       restSync;
	wire       sclkSync;
	wire       dinSync;
	wire       sclSync;
	wire       sdaSync;
	reg        restPrev_q;
	reg        sclkPrev_q;
	reg        sclPrev_q;
	reg        sdaPrev_q;
	reg  [2:0] st_q;
	reg  [2:0] st_d;
	reg  [2:0] tw_q;
	reg  [2:0] tw_d;
	reg  [7:0] rdyCnt_q;
	reg        powerOn_q;
	reg        ackDrv_q;
	reg        ackDrv_d;
	reg        pushByte;
	wire       restartRise;
	wire       sclkRise;
	wire       sclRise;
	wire       sclFall;
	wire       twStart;
	wire       twStop;
	wire       serMode;
	wire       twMode;
	wire       loading;
	wire       serShift;
	wire       twShift;
	wire [7:0] serByte;
	wire [7:0] twByte;
	wire       serDone;
	wire       twDone;
	wire       twClear;

	// pin synchronisers, idle high for pulled-up pins
	sicp_pin_sync #(.RST_VAL(1'b1)) uRest (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.pinIn   (restartPin_n),
		.level_q (restSync)
	);
	sicp_pin_sync #(.RST_VAL(1'b0)) uSclk (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.pinIn   (serClk),
		.level_q (sclkSync)
	);
	sicp_pin_sync #(.RST_VAL(1'b1)) uDin (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.pinIn   (serData),
		.level_q (dinSync)
	);
	sicp_pin_sync #(.RST_VAL(1'b1)) uScl (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.pinIn   (twScl),
		.level_q (sclSync)
	);
	sicp_pin_sync #(.RST_VAL(1'b1)) uSda (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.pinIn   (twSdaIn),
		.level_q (sdaSync)
	);

	// edge history on filtered levels
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			restPrev_q <= 1'b1;
			sclkPrev_q <= 1'b0;
			sclPrev_q  <= 1'b1;
			sdaPrev_q  <= 1'b1;
		end else begin
			restPrev_q <= restSync;
			sclkPrev_q <= sclkSync;
			sclPrev_q  <= sclSync;
			sdaPrev_q  <= sdaSync;
		end
	end

	// restart pulse counts only while the pin is still dedicated
	// rising end of the low pulse starts a new configuration
	assign restartRise = restSync && !restPrev_q && !restartIsGpio;
	assign sclkRise    = sclkSync && !sclkPrev_q;
	assign sclRise     = sclSync && !sclPrev_q;
	assign sclFall     = !sclSync && sclPrev_q;
	// data edges while clock high mark start and stop
	assign twStart     = sclSync && sclPrev_q && !sdaSync && sdaPrev_q;
	assign twStop      = sclSync && sclPrev_q && sdaSync && !sdaPrev_q;

	// decode of the captured mode code
	assign serMode = (modeCap_q == `SICP_MODE_SERIAL);
	assign twMode  = (modeCap_q == `SICP_MODE_TWIRE);
	// neither link works once the restart pin is general I/O
	assign loading = (st_q == ST_LOAD) && !restartIsGpio;

	// one bit per rising shift clock while loading
	assign serShift = loading && serMode && sclkRise;
	// sample data on the clock rise, where it is stable
	assign twShift  = loading && twMode && sclRise &&
	                  (tw_q == TW_ADDR || tw_q == TW_DATA);
	assign twClear  = twStart || twStop || !loading;

	// msb-first byte assembly for each link
	sicp_shift_byte uSerByte (
		.clk      (ref_clk),
		.rst_n    (rst_n),
		.clear    (!loading),
		.shiftEn  (serShift),
		.bitIn    (dinSync),
		.byte_q   (serByte),
		.count_q  (),
		.byteDone (serDone)
	);
	sicp_shift_byte uTwByte (
		.clk      (ref_clk),
		.rst_n    (rst_n),
		.clear    (twClear),
		.shiftEn  (twShift),
		.bitIn    (sdaSync),
		.byte_q   (twByte),
		.count_q  (),
		.byteDone (twDone)
	);

	// top-level sequencing
	always @* begin
		st_d = st_q;
		case (st_q)
		ST_IDLE: begin
			if (!restartIsGpio)
				st_d = ST_READY;
		end
		ST_FLASH: begin
			// flash attempt ends in done or falls back to the link
			if (flashBootDone)
				st_d = flashBootOk ? ST_DONE : ST_LOAD;
		end
		ST_READY: begin
			if (rdyCnt_q == 8'h00)
				st_d = (twMode && powerOn_q && flashHasImage) ?
				       ST_FLASH : ST_LOAD;
		end
		ST_LOAD: begin
			if (!serMode && !twMode)
				st_d = ST_FAIL;
			else if (cfgFail)
				st_d = ST_FAIL;
			else if (cfgComplete)
				st_d = ST_DONE;
		end
		ST_DONE: st_d = ST_DONE;
		ST_FAIL: st_d = ST_FAIL;
		default: st_d = ST_IDLE;
		endcase
		if (restartRise)
			st_d = ST_READY;
	end

	// state, ready pulse timing and mode capture
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= ST_IDLE;
			rdyCnt_q  <= 8'h00;
			ready_q   <= `SICP_READY_RST;
			done_q    <= `SICP_DONE_RST;
			modeCap_q <= 3'h0;
			powerOn_q <= 1'b1;
			flashBootReq_q <= 1'b0;
		end else begin
			st_q <= st_d;
			// ready is a high pulse on entry to the ready state
			if (st_d == ST_READY && st_q != ST_READY) begin
				rdyCnt_q <= READY_CYC[7:0] - 8'h1;
				ready_q  <= 1'b1;
			end else if (st_q == ST_READY && rdyCnt_q != 8'h00) begin
				rdyCnt_q <= rdyCnt_q - 8'h1;
			end else begin
				ready_q <= 1'b0;
			end
			// capture mode pins on the rising edge of ready
			if (st_d == ST_READY && st_q != ST_READY)
				modeCap_q <= modePins;
			// done only after success, cleared on any restart
			done_q <= (st_d == ST_DONE);
			// flash boot only from power-on, not after a restart
			if (restartRise)
				powerOn_q <= 1'b0;
			else if (st_q == ST_FLASH && st_d != ST_FLASH)
				powerOn_q <= 1'b0;
			flashBootReq_q <= (st_d == ST_FLASH);
		end
	end

	// two-wire slave sequencing
	always @* begin
		tw_d     = tw_q;
		ackDrv_d = ackDrv_q;
		pushByte = 1'b0;
		case (tw_q)
		TW_IDLE: ;
		TW_ADDR: begin
			if (twDone) begin
				// read requests get no answer at all
				if ({twByte[6:0], sdaSync} ==
				    {`SICP_SLAVE_ADDR, `SICP_DIR_WRITE})
					tw_d = TW_AACK;
				else
					tw_d = TW_SKIP;
			end
		end
		TW_AACK, TW_DACK: begin
			// drive low after the eighth fall, before pulse nine
			if (sclFall && !ackDrv_q)
				ackDrv_d = 1'b1;
			else if (sclFall && ackDrv_q) begin
				// release after the ninth pulse ends
				ackDrv_d = 1'b0;
				tw_d     = TW_DATA;
			end
		end
		TW_DATA: begin
			if (twDone) begin
				tw_d     = TW_DACK;
				pushByte = 1'b1;
			end
		end
		TW_SKIP: ;
		default: tw_d = TW_IDLE;
		endcase
		if (twStart)
			tw_d = TW_ADDR;
		if (twStop || !(loading && twMode)) begin
			tw_d     = TW_IDLE;
			ackDrv_d = 1'b0;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tw_q     <= TW_IDLE;
			ackDrv_q <= 1'b0;
		end else begin
			tw_q     <= tw_d;
			ackDrv_q <= ackDrv_d;
		end
	end

	// line driven only low, only for acknowledge
	assign twSdaOut = 1'b0;
	assign twSdaOe  = ackDrv_q;

	// byte output to the configuration core, write only
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgByte_q  <= 8'h00;
			cfgValid_q <= 1'b0;
		end else begin
			// serial bytes go one way, into the core
			cfgValid_q <= serDone || pushByte;
			if (serDone)
				cfgByte_q <= {serByte[6:0], dinSync};
			else if (pushByte)
				cfgByte_q <= {twByte[6:0], sdaSync};
		end
	end

	// cascade output only in serial mode with chaining on
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			serCascade_q <= 1'b0;
		else if (serMode && chainEn && st_q == ST_DONE)
			serCascade_q <= dinSync;  // pass-through once this one is full
		else
			serCascade_q <= 1'b0;
	end
endmodule // sicp_config_port
`default_nettype wire

//--- verification/sicp_config_port_sva.sv
// Purpose: port-level checks of the configuration port
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   restart checks need a low pulse of eight cycles or more
`timescale 1ns/10ps
`default_nettype none
`include "sicp_consts.vh"
module sicp_config_port_sva #(
	parameter READY_CYC = 8
) (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       restartPin_n,
	input wire logic       restartIsGpio,
	input wire logic [2:0] modePins,
	input wire logic       chainEn,
	input wire logic       twScl,
	input wire logic       twSdaOut,
	input wire logic       twSdaOe,
	input wire logic       serCascade_q,
	input wire logic       ready_q,
	input wire logic       done_q,
	input wire logic [2:0] modeCap_q,
	input wire logic       cfgFail,
	input wire logic       cfgValid_q
);
	logic [7:0] readyCnt_q;
	logic [7:0] lowCnt_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// width counters, a repetition cannot take a parameter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			readyCnt_q <= 8'h00;
			lowCnt_q   <= 8'h00;
		end else begin
			readyCnt_q <= ready_q ? readyCnt_q + 8'h01 : 8'h00;
			lowCnt_q   <= restartPin_n ? 8'h00 : lowCnt_q + 8'h01;
		end
	end
	a_ready_width: assert property (
		$fell(ready_q) |-> readyCnt_q == READY_CYC)
		else $error("ready pulse width wrong");
	a_mode_capture: assert property (
		$rose(ready_q) |-> modeCap_q == $past(modePins))
		else $error("mode not captured at ready rise");
	a_mode_hold: assert property (
		!$rose(ready_q) |-> $stable(modeCap_q))
		else $error("captured mode moved without ready rise");
	a_sda_ack_only: assert property (
		twSdaOe |-> modeCap_q == `SICP_MODE_TWIRE && !twSdaOut)
		else $error("data line driven outside two-wire ack");
	a_ack_scl_low: assert property (
		$changed(twSdaOe) |-> !twScl)
		else $error("ack drive changed while clock high");
	a_cascade_mode: assert property (
		serCascade_q |-> modeCap_q == `SICP_MODE_SERIAL && $past(chainEn))
		else $error("cascade driven outside serial chain");
	a_fail_done: assert property (
		cfgFail |-> ##[1:3] !done_q)
		else $error("done high after failure");
	a_restart_ready: assert property (
		$rose(restartPin_n) && lowCnt_q >= 8'h08 && !restartIsGpio
		|-> ##[2:14] $rose(ready_q))
		else $error("restart pulse gave no ready");
	a_gpio_block: assert property (
		restartIsGpio |-> !$rose(ready_q))
		else $error("ready rose with restart pin as gpio");
	a_valid_pulse: assert property (
		cfgValid_q |-> !ready_q ##1 !cfgValid_q)
		else $error("byte strobe too long or during ready");
	c_ready: cover property ($rose(ready_q));
	c_byte: cover property (cfgValid_q);
	c_ack: cover property ($rose(twSdaOe));
	c_cascade: cover property (serCascade_q);
endmodule // sicp_config_port_sva
bind sicp_config_port sicp_config_port_sva #(.READY_CYC(READY_CYC)) sva_i (
	.ref_clk(ref_clk), .rst_n(rst_n), .restartPin_n(restartPin_n),
	.restartIsGpio(restartIsGpio), .modePins(modePins), .chainEn(chainEn),
	.twScl(twScl), .twSdaOut(twSdaOut), .twSdaOe(twSdaOe),
	.serCascade_q(serCascade_q), .ready_q(ready_q), .done_q(done_q),
	.modeCap_q(modeCap_q), .cfgFail(cfgFail), .cfgValid_q(cfgValid_q));
`default_nettype wire

//--- verification/sicp_host_model.sv
// Purpose: host side of the serial and two-wire configuration links
// Assumes: tasks are entered at a falling ref_clk edge
// Notes:   each clock level lasts 64 ns, above the pin filter latency
`timescale 1ns/10ps
`default_nettype none
module sicp_host_model (
	input  wire logic twSdaOe,
	input  wire logic twSdaOut,
	output var  logic twScl,
	output wire logic twSdaIn,
	output var  logic serClk,
	output var  logic serData
);
	logic sdaLow;
	initial begin
		twScl   = 1'b1;
		sdaLow  = 1'b0;
		serClk  = 1'b0;
		serData = 1'b1;
	end
	assign twSdaIn = !(sdaLow || (twSdaOe && !twSdaOut));
	// msb first, clock still between bytes
	task automatic serByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			serData = b[i];
			#64 serClk = 1'b1;
			#64 serClk = 1'b0;
		end
		// release to the pull-up level, one step apart from the next byte
		#8 serData = 1'b1;
		#8;
	endtask
	task automatic serLevel(input logic v);
		serData = v;
	endtask
	task automatic i2cStart();
		#64 sdaLow = 1'b1;
		#64 twScl = 1'b0;
	endtask
	// data in low phase, ninth pulse released
	task automatic i2cByte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#48 sdaLow = !b[i];
			#16 twScl = 1'b1;
			#64 twScl = 1'b0;
		end
		#48 sdaLow = 1'b0;
		#16 twScl = 1'b1;
		#32 ack = !twSdaIn;
		#32 twScl = 1'b0;
	endtask
	task automatic i2cStop();
		#48 sdaLow = 1'b1;
		#16 twScl = 1'b1;
		#64 sdaLow = 1'b0;
		#64;
	endtask
endmodule // sicp_host_model
`default_nettype wire

//--- verification/tb_serial_i2c_config_port.sv
// Purpose: self-checking bench of the configuration port
// Assumes: host model drives both links, bench plays flash and core
// Notes:   expected bytes kept in a queue, popped at each strobe
`timescale 1ns/10ps
`default_nettype none
`include "sicp_consts.vh"
module tb_serial_i2c_config_port;
	logic ref_clk = 1'b0, rst_n, restartPin_n, restartIsGpio, chainEn;
	logic [2:0] modePins;
	logic flashHasImage, flashBootDone, flashBootOk, cfgComplete, cfgFail;
	wire logic serClk, serData, serCascade_q, twScl, twSdaIn, twSdaOut;
	wire logic twSdaOe, ready_q, done_q, flashBootReq_q, cfgValid_q;
	wire logic [2:0] modeCap_q;
	wire logic [7:0] cfgByte_q;
	logic [7:0] expQ[$];
	int err_count, checked, cyc;
	sicp_config_port #(.READY_CYC(8)) sicp_config_port_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .restartPin_n(restartPin_n),
		.restartIsGpio(restartIsGpio), .modePins(modePins), .chainEn(chainEn),
		.serClk(serClk), .serData(serData), .serCascade_q(serCascade_q),
		.twScl(twScl), .twSdaIn(twSdaIn), .twSdaOut(twSdaOut),
		.twSdaOe(twSdaOe), .ready_q(ready_q), .done_q(done_q),
		.modeCap_q(modeCap_q), .flashHasImage(flashHasImage),
		.flashBootDone(flashBootDone), .flashBootOk(flashBootOk),
		.flashBootReq_q(flashBootReq_q), .cfgComplete(cfgComplete),
		.cfgFail(cfgFail), .cfgByte_q(cfgByte_q), .cfgValid_q(cfgValid_q));
	sicp_host_model host_i (
		.twSdaOe(twSdaOe), .twSdaOut(twSdaOut), .twScl(twScl),
		.twSdaIn(twSdaIn), .serClk(serClk), .serData(serData));
	always #4 ref_clk = !ref_clk;
	task automatic chk1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk8(input string nm, input logic [7:0] e,
	                    input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic results();
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// hang guard, whole run is a few thousand cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 12000) begin
			err_count++;
			results();
		end
	end
	// reference model: every strobe must match the next queued byte
	always @(negedge ref_clk) begin
		if (cfgValid_q === 1'b1 && expQ.size() == 0)
			chk1("unexpected byte", 1'b0, 1'b1);
		else if (cfgValid_q === 1'b1)
			chk8("cfgByte", expQ.pop_front(), cfgByte_q);
	end
	task automatic waitReady(input logic [2:0] m);
		int n;
		n = 0;
		while (ready_q !== 1'b1 && n < 60) begin
			@(negedge ref_clk);
			n++;
		end
		chk1("ready", 1'b1, ready_q);
		chk8("modeCap", {5'h00, m}, {5'h00, modeCap_q});
		while (ready_q !== 1'b0 && n < 120) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic i2cXfer(input logic [7:0] ab, input logic good);
		logic [7:0] b;
		logic ack;
		host_i.i2cStart();
		host_i.i2cByte(ab, ack);
		chk1("addrAck", good, ack);
		for (int i = 0; i < 3; i++) begin
			b = 8'($urandom);
			if (good)
				expQ.push_back(b);
			host_i.i2cByte(b, ack);
			chk1("dataAck", good, ack);
		end
		host_i.i2cStop();
	endtask
	// main sequence: flash boot, two-wire, serial, cascade, gpio
	initial begin
		{rst_n, restartIsGpio, chainEn, flashBootDone, flashBootOk} = 5'h00;
		{cfgComplete, cfgFail, err_count, checked, cyc} = '0;
		restartPin_n = 1'b1;
		modePins = `SICP_MODE_TWIRE;
		flashHasImage = 1'b1;
		void'($urandom(12));
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		waitReady(`SICP_MODE_TWIRE);
		chk1("flashReq", 1'b1, flashBootReq_q);
		pulse(flashBootDone);
		chk1("flashReq", 1'b0, flashBootReq_q);
		i2cXfer({`SICP_SLAVE_ADDR, `SICP_DIR_WRITE}, 1'b1);
		i2cXfer(8'hA2, 1'b0);
		i2cXfer({`SICP_SLAVE_ADDR, 1'h1}, 1'b0);
		i2cXfer({`SICP_SLAVE_ADDR, `SICP_DIR_WRITE}, 1'b1);
		repeat (10) @(negedge ref_clk);
		chk8("pending", 8'h00, 8'(expQ.size()));
		pulse(cfgFail);
		chk1("done", 1'b0, done_q);
		// erase before reload: flash emptied, then a restart pulse
		flashHasImage = 1'b0;
		for (int m = 0; m < 2; m++) begin
			modePins = m[0] ? `SICP_MODE_SERIAL : 3'h7;
			restartPin_n = 1'b0;
			repeat (10) @(negedge ref_clk);
			restartPin_n = 1'b1;
			waitReady(modePins);
			if (!m[0]) begin
				// unknown code: no link answers, done stays low
				i2cXfer({`SICP_SLAVE_ADDR, `SICP_DIR_WRITE}, 1'b0);
				chk1("done", 1'b0, done_q);
			end
		end
		for (int i = 0; i < 16; i++) begin
			expQ.push_back(8'($urandom));
			host_i.serByte(expQ[$]);
		end
		repeat (20) @(negedge ref_clk);
		chk8("pending", 8'h00, 8'(expQ.size()));
		pulse(cfgComplete);
		chk1("done", 1'b1, done_q);
		chainEn = 1'b1;
		for (int v = 0; v < 2; v++) begin
			host_i.serLevel(v[0]);
			repeat (12) @(negedge ref_clk);
			chk1("cascade", v[0], serCascade_q);
		end
		restartIsGpio = 1'b1;
		restartPin_n = 1'b0;
		repeat (10) @(negedge ref_clk);
		restartPin_n = 1'b1;
		repeat (30) @(negedge ref_clk);
		chk1("done", 1'b1, done_q);
		results();
	end
endmodule // tb_serial_i2c_config_port
`default_nettype wire
